//--- design/dbs_pkg.sv
// Constants and carrier types for the burst-of-two SRAM pin port.
// Assumes one system clock; all strobe pins arrive as one-cycle edge marks.
package dbs_pkg;

  localparam int DBS_NIB_W      = 4;
  localparam int DBS_LANE_W     = 9;
  localparam int DBS_X8_W       = 8;
  localparam int DBS_SEED_MIN_W = 18;
  localparam int DBS_BURST_LEN  = 2;
  localparam int DBS_SYNC_DEPTH = 2;
  localparam logic DBS_OE_RST   = 1'b0;
  localparam logic DBS_ECHO_RST = 1'b0;

  typedef enum logic [1:0] {
    DBS_WR_IDLE  = 2'b00,
    DBS_WR_BEAT0 = 2'b01,
    DBS_WR_BEAT1 = 2'b10
  } dbs_wr_st_t;

  typedef enum logic [1:0] {
    DBS_RD_IDLE   = 2'b00,
    DBS_RD_LOADED = 2'b01,
    DBS_RD_BEAT0  = 2'b10,
    DBS_RD_BEAT1  = 2'b11
  } dbs_rd_st_t;

  // Edge marks of the four strobe pins in one cycle
  typedef struct packed {
    logic strobe_p;
    logic strobe_n;
    logic timing_p;
    logic timing_n;
  } dbs_edge_t;

endpackage

//--- design/dbs_port.sv
// Pin-level command and data port of a burst-of-two double-data-rate SRAM.
// Assumes every pin is synchronous to SYS_CLK and each strobe pin is high
// for one cycle per rising edge of the clock it stands for.
`timescale 1ns/100ps

module dbs_port #(
  parameter int DATA_W    = 36,
  parameter int ADDR_W    = 19,
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_N,
  input  wire logic                 CLK_EN,
  input  wire logic                 INPUT_STROBE_P,
  input  wire logic                 INPUT_STROBE_N,
  input  wire logic                 OUTPUT_TIMING_P,
  input  wire logic                 OUTPUT_TIMING_N,
  input  wire logic                 SINGLE_CLOCK_MODE,
  input  wire logic                 LOAD_STROBE_N,
  input  wire logic                 READ_WRITE_SEL,
  input  wire logic [ADDR_W-1:0]    ADDR,
  input  wire logic [1:0]           NIBBLE_WRITE_SEL_N,
  input  wire logic [DATA_W/9:0]    BYTE_WRITE_SEL_N,
  input  wire logic [DATA_W-1:0]    DQ_IN,
  output logic      [DATA_W-1:0]    DQ_OUT,
  output logic                      DQ_OE,
  output logic                      ECHO_OUT_P,
  output logic                      ECHO_OUT_N,
  output logic                      WR_STALL
);
  import dbs_pkg::*;

  localparam bit NIB_MODE = (DATA_W == DBS_X8_W);
  localparam int LANE_W   = NIB_MODE ? DBS_NIB_W : DBS_LANE_W;
  localparam int LANES    = DATA_W / LANE_W;
  localparam bit SEED     = (DATA_W >= DBS_SEED_MIN_W);
  localparam int IDX_W    = ADDR_W + 1;
  localparam int PTR_W    = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W    = $clog2(BUF_DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(BUF_DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(BUF_DEPTH - 1);

  typedef struct packed {
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  wen;
  } dbs_ent_t;

  typedef struct packed {
    dbs_wr_st_t                 wr_st;
    logic [ADDR_W-1:0]          wr_addr;
    dbs_rd_st_t                 rd_st;
    logic [DATA_W-1:0]          rd_word0;
    logic [DATA_W-1:0]          rd_word1;
    dbs_ent_t [BUF_DEPTH-1:0]   ent;
    logic [PTR_W-1:0]           wp;
    logic [PTR_W-1:0]           rp;
    logic [CNT_W-1:0]           cnt;
    logic [DATA_W-1:0]          dq_out;
    logic                       dq_oe;
    logic                       echo_p;
    logic                       echo_n;
    logic                       wr_stall;
  } dbs_state_t;

  dbs_state_t        q;
  dbs_state_t        next_q;
  dbs_edge_t         ev;
  logic              rst_meta;
  logic              rst_sync;
  logic              out_p;
  logic              out_n;
  logic              cmd;
  logic              rd_take;
  logic              capture;
  logic              space;
  logic              push;
  logic              pop;
  logic              burst_start_bit;
  logic [LANES-1:0]  lane_wen;
  logic [IDX_W-1:0]  rd_idx0;
  logic [IDX_W-1:0]  rd_idx1;
  logic [DATA_W-1:0] rd_data0;
  logic [DATA_W-1:0] rd_data1;
  dbs_ent_t          head;

  // Burst index: narrow widths count from zero, wide ones from the address LSB
  function automatic logic [IDX_W-1:0] beat_idx(input logic [ADDR_W-1:0] a,
                                                input logic beat);
    if (SEED) begin
      beat_idx = {1'b0, a[ADDR_W-1:1], a[0] ^ beat};
    end else begin
      beat_idx = {a, beat};
    end
  endfunction

  // Reset release through two flops
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign ev              = '{strobe_p: INPUT_STROBE_P, strobe_n: INPUT_STROBE_N,
                             timing_p: OUTPUT_TIMING_P, timing_n: OUTPUT_TIMING_N};
  assign out_p           = SINGLE_CLOCK_MODE ? ev.strobe_p : ev.timing_p;
  assign out_n           = SINGLE_CLOCK_MODE ? ev.strobe_n : ev.timing_n;
  assign burst_start_bit = ADDR[0];
  // A transaction exists only where the load strobe is low at a p edge
  assign cmd             = ev.strobe_p && !LOAD_STROBE_N;
  assign rd_take         = cmd && READ_WRITE_SEL &&
                           (q.rd_st == DBS_RD_IDLE || q.rd_st == DBS_RD_BEAT1);
  assign rd_idx0         = beat_idx(ADDR, 1'b0);
  assign rd_idx1         = beat_idx(ADDR, 1'b1);
  assign capture         = (ev.strobe_n && q.wr_st == DBS_WR_BEAT0) ||
                           (ev.strobe_p && q.wr_st == DBS_WR_BEAT1);
  assign space           = (q.cnt != FULL_CNT);
  assign push            = capture && space;
  // The array port serves a read first, so draining stalls under reads
  assign pop             = (q.cnt != '0) && !rd_take;
  assign head            = q.ent[q.rp];

  // One storage array per lane, so a deselected lane is never touched
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] mem [2**IDX_W];

    if (NIB_MODE) begin : g_nib
      assign lane_wen[l] = !NIBBLE_WRITE_SEL_N[l];
    end else begin : g_byte
      assign lane_wen[l] = !BYTE_WRITE_SEL_N[l];
    end

    assign rd_data0[l*LANE_W +: LANE_W] = mem[rd_idx0];
    assign rd_data1[l*LANE_W +: LANE_W] = mem[rd_idx1];

    always_ff @(posedge SYS_CLK) begin
      if (CLK_EN && pop && head.wen[l]) begin
        mem[head.idx] <= head.data[l*LANE_W +: LANE_W];
      end
    end
  end

  always_comb begin
    next_q          = q;
    next_q.wr_stall = capture && !space;

    // Write beats: first on the n edge after the command, second on the p edge
    if (capture) begin
      if (push) begin
        next_q.ent[q.wp].data = DQ_IN;
        next_q.ent[q.wp].wen  = lane_wen;
        next_q.ent[q.wp].idx  = beat_idx(q.wr_addr, q.wr_st == DBS_WR_BEAT1);
        next_q.wp             = (q.wp == LAST_PTR) ? '0 : q.wp + 1'b1;
      end
      next_q.wr_st = (q.wr_st == DBS_WR_BEAT0) ? DBS_WR_BEAT1 : DBS_WR_IDLE;
    end
    if (cmd && !READ_WRITE_SEL) begin
      next_q.wr_st   = DBS_WR_BEAT0;
      next_q.wr_addr = ADDR;
    end

    if (pop) begin
      next_q.rp = (q.rp == LAST_PTR) ? '0 : q.rp + 1'b1;
    end
    next_q.cnt = q.cnt + CNT_W'(push) - CNT_W'(pop);

    // Read beats leave on the output timing edges, or on the input strobe edges in single clock mode
    if (out_p && q.rd_st == DBS_RD_LOADED) begin
      next_q.dq_out = q.rd_word0;
      next_q.dq_oe  = 1'b1;
      next_q.rd_st  = DBS_RD_BEAT0;
    end else if (out_n && q.rd_st == DBS_RD_BEAT0) begin
      next_q.dq_out = q.rd_word1;
      next_q.rd_st  = DBS_RD_BEAT1;
    end else if (out_p && q.rd_st == DBS_RD_BEAT1) begin
      next_q.dq_oe  = 1'b0;
      next_q.rd_st  = DBS_RD_IDLE;
    end
    if (rd_take) begin
      next_q.rd_st    = DBS_RD_LOADED;
      next_q.rd_word0 = rd_data0;
      next_q.rd_word1 = rd_data1;
    end

    if (out_p) begin
      next_q.echo_p = 1'b1;
      next_q.echo_n = 1'b0;
    end else if (out_n) begin
      next_q.echo_p = 1'b0;
      next_q.echo_n = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      q        <= '0;
      q.dq_oe  <= DBS_OE_RST;
      q.echo_p <= DBS_ECHO_RST;
      q.echo_n <= DBS_ECHO_RST;
    end else if (CLK_EN) begin
      q <= next_q;
    end
  end

  assign DQ_OUT     = q.dq_out;
  assign DQ_OE      = q.dq_oe;
  assign ECHO_OUT_P = q.echo_p;
  assign ECHO_OUT_N = q.echo_n;
  assign WR_STALL   = q.wr_stall;

  a_oe_idle_off: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    (q.rd_st == DBS_RD_IDLE || q.rd_st == DBS_RD_LOADED) && !$past(q.dq_oe) |-> !DQ_OE)
    else $error("Data drivers on without a read beat");

  a_read_beat0: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && out_p && q.rd_st == DBS_RD_LOADED
    |=> DQ_OE && DQ_OUT == $past(q.rd_word0))
    else $error("First read beat not driven on output p edge");

  a_read_beat1: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && out_n && q.rd_st == DBS_RD_BEAT0 && !rd_take
    |=> DQ_OE && DQ_OUT == $past(q.rd_word1) && q.rd_st == DBS_RD_BEAT1)
    else $error("Second read beat not driven on output n edge");

  a_write_capture: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && push |=> q.ent[$past(q.wp)].data == $past(DQ_IN))
    else $error("Write beat not captured from data pins");

  a_lane_mask: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && push |=> q.ent[$past(q.wp)].wen == $past(lane_wen))
    else $error("Write select not sampled with its data beat");

  a_write_cmd: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && cmd && !READ_WRITE_SEL
    |=> q.wr_st == DBS_WR_BEAT0 && q.wr_addr == $past(ADDR))
    else $error("Write command not loaded at input p edge");

  a_no_load_idle: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && LOAD_STROBE_N && q.wr_st == DBS_WR_IDLE && q.rd_st == DBS_RD_IDLE
    |=> q.wr_st == DBS_WR_IDLE && q.rd_st == DBS_RD_IDLE)
    else $error("Transaction started without load strobe");

  a_burst_ends: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && ev.strobe_p && LOAD_STROBE_N && q.wr_st == DBS_WR_BEAT1
    |=> q.wr_st == DBS_WR_IDLE)
    else $error("Write burst did not end after two beats");

  a_echo_follow: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && out_p |=> ECHO_OUT_P && !ECHO_OUT_N)
    else $error("Echo clock does not follow output p edge");

  a_index_seed: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    rd_idx0[0] == (SEED ? burst_start_bit : 1'b0) && rd_idx1[0] != rd_idx0[0])
    else $error("Burst counter seed wrong for this width");

  a_stall_full: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && capture && !space |=> WR_STALL)
    else $error("Dropped write beat not flagged");

  a_stall_quiet: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && !(capture && !space) |=> !WR_STALL)
    else $error("Stall flagged without a dropped beat");

  a_read_take: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && rd_take |=> q.rd_st == DBS_RD_LOADED && q.rd_word0 == $past(rd_data0))
    else $error("Read command not loaded");

  a_read_pair: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && rd_take |=> q.rd_word1 == $past(rd_data1))
    else $error("Second read word not loaded");

  a_read_release: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && out_p && q.rd_st == DBS_RD_BEAT1 && !rd_take |=> !DQ_OE && q.rd_st == DBS_RD_IDLE)
    else $error("Data drivers not released after burst");

  a_echo_n_follow: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && out_n && !out_p |=> !ECHO_OUT_P && ECHO_OUT_N)
    else $error("Echo clock does not follow output n edge");

  a_single_clock: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    SINGLE_CLOCK_MODE |-> out_p == INPUT_STROBE_P && out_n == INPUT_STROBE_N)
    else $error("Single clock mode not using input strobes");

  a_write_beat0: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && ev.strobe_n && q.wr_st == DBS_WR_BEAT0 && !cmd |=> q.wr_st == DBS_WR_BEAT1)
    else $error("First write beat not taken on input n edge");

  a_cnt_bound: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    q.cnt <= FULL_CNT)
    else $error("Write buffer count beyond its depth");

  a_read_port: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && rd_take |=> q.rp == $past(q.rp))
    else $error("Buffer drained while a read held the array");

  a_push_count: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && push && !pop |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("Write buffer count did not grow");

  a_addr_hold: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && !(cmd && !READ_WRITE_SEL) |=> q.wr_addr == $past(q.wr_addr))
    else $error("Write address taken without a write command");

  a_narrow_lsb: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    !SEED |-> rd_idx0[0] == 1'b0 && rd_idx1[0] == 1'b1)
    else $error("Narrow burst does not start at zero");

  a_pair_upper: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    rd_idx0[IDX_W-1:1] == rd_idx1[IDX_W-1:1])
    else $error("Burst words leave their address pair");

  a_beat0_hold: assert property (
    @(posedge SYS_CLK) disable iff (!rst_sync)
    CLK_EN && q.rd_st == DBS_RD_BEAT0 && !out_n |=> DQ_OUT == $past(DQ_OUT) && DQ_OE)
    else $error("First read beat not held until n edge");

endmodule

//--- verification/dbs_ctrl_model.sv
// Far-side memory controller: free-running strobe pulses and write data pins.
// Assumes the bench times commands to the strobe phase this model shows.
`timescale 1ns/100ps

module dbs_ctrl_model #(
  parameter int DATA_W = 18
) (
  input  wire logic              SYS_CLK,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic                   strobe_p,
  output logic                   strobe_n,
  output logic                   timing_p,
  output logic                   timing_n,
  output logic      [DATA_W-1:0] dq_in
);
  logic              ph;
  logic [DATA_W-1:0] last;

  initial ph = 1'b0;
  initial last = '0;
  // Input strobes alternate p and n every cycle; output strobes sit one phase on
  always @(negedge SYS_CLK) ph <= ~ph;
  assign strobe_p = ~ph;
  assign strobe_n = ph;
  assign timing_p = ph;
  assign timing_n = ~ph;
  // Both beats of a burst are driven; released pins show the inverse of the last word
  always @(negedge SYS_CLK) if (wr_en) last <= wr_data;
  assign dq_in = wr_en ? wr_data : ~last;
endmodule

//--- verification/tb_ddr_burst2_sram_port.sv
// Self-checking bench for the burst-of-two port, 18-bit wide, 4 address bits.
// Assumes the controller model paces strobes; data is checked against a local array.
`timescale 1ns/100ps

module tb_ddr_burst2_sram_port;
  localparam int DW = 18;
  localparam int AW = 4;
  typedef struct packed {
    logic [AW-1:0] a;
    logic [DW-1:0] w0;
    logic [DW-1:0] w1;
    logic [2:0]    m0;
    logic [2:0]    m1;
  } dbs_row_t;
  logic          sys_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          sc_mode = 1'b0;
  logic          load_n = 1'b1;
  logic          rw = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [2:0]    bws_n = 3'h7;
  logic          wr_en = 1'b0;
  logic [DW-1:0] wr_data = '0;
  logic          sp, sn, tp, tn, oe, ep, en, stall;
  logic [DW-1:0] dq_in, dq_out;
  logic [DW-1:0] ref_mem [16];
  int            num_errors = 0;
  int            total_checks = 0;
  dbs_row_t      rows [5] = '{
    '{4'h0, 18'h1_2345, 18'h2_6789, 3'h4, 3'h4},
    '{4'h2, 18'h0_abcd, 18'h3_0f0f, 3'h4, 3'h4},
    '{4'h3, 18'h1_1111, 18'h2_2222, 3'h4, 3'h4},
    '{4'h0, 18'h3_ffff, 18'h0_0000, 3'h6, 3'h5},
    '{4'h3, 18'h0_5a5a, 18'h3_a5a5, 3'h5, 3'h7}};

  always #20 sys_clk = ~sys_clk;

  dbs_ctrl_model #(.DATA_W(DW)) u_ctl (.SYS_CLK(sys_clk), .wr_en(wr_en), .wr_data(wr_data),
    .strobe_p(sp), .strobe_n(sn), .timing_p(tp), .timing_n(tn), .dq_in(dq_in));

  dbs_port #(.DATA_W(DW), .ADDR_W(AW), .BUF_DEPTH(2)) u_dut (.SYS_CLK(sys_clk),
    .RST_N(rst_n), .CLK_EN(1'b1), .INPUT_STROBE_P(sp), .INPUT_STROBE_N(sn),
    .OUTPUT_TIMING_P(tp), .OUTPUT_TIMING_N(tn), .SINGLE_CLOCK_MODE(sc_mode),
    .LOAD_STROBE_N(load_n), .READ_WRITE_SEL(rw), .ADDR(addr), .NIBBLE_WRITE_SEL_N(2'b11),
    .BYTE_WRITE_SEL_N(bws_n), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(oe), .ECHO_OUT_P(ep),
    .ECHO_OUT_N(en), .WR_STALL(stall));

  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Next falling edge that precedes an input strobe p cycle
  task automatic sync_p();
    @(negedge sys_clk);
    #1;
    if (sp !== 1'b1) begin
      @(negedge sys_clk);
      #1;
    end
  endtask

  task automatic wr(input dbs_row_t r);
    sync_p();
    load_n = 1'b0;
    rw = 1'b0;
    addr = r.a;
    @(negedge sys_clk);
    #1;
    load_n = 1'b1;
    wr_en = 1'b1;
    wr_data = r.w0;
    bws_n = r.m0;
    @(negedge sys_clk);
    #1;
    wr_data = r.w1;
    bws_n = r.m1;
    @(negedge sys_clk);
    #1;
    wr_en = 1'b0;
    bws_n = 3'h7;
    for (int b = 0; b < 2; b++) begin
      for (int l = 0; l < 2; l++) begin
        if (!(b ? r.m1[l] : r.m0[l]))
          ref_mem[{r.a[3:1], r.a[0] ^ b[0]}][9*l+:9] = b ? r.w1[9*l+:9] : r.w0[9*l+:9];
      end
    end
    chk("stall", 0, stall);
  endtask

  task automatic rd(input logic [AW-1:0] a);
    int n;
    repeat (6) @(negedge sys_clk);
    sync_p();
    load_n = 1'b0;
    rw = 1'b1;
    addr = a;
    @(negedge sys_clk);
    #1;
    load_n = 1'b1;
    addr = ~a;
    n = 0;
    while (oe !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 8) begin
      num_errors++;
      print_verdict();
    end
    chk("beat0", ref_mem[{a[3:1], a[0]}], dq_out);
    chk("echo_p", 1, ep);
    @(posedge sys_clk);
    #1;
    chk("beat1", ref_mem[{a[3:1], ~a[0]}], dq_out);
    chk("echo_n", 1, en);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("oe_idle", 0, oe);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    chk("oe_rst", 0, oe);
    chk("echo_rst", 0, {en, ep});
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    foreach (rows[i]) begin
      wr(rows[i]);
      rd(rows[i].a);
    end
    // Strobe with load high and read selected starts nothing
    sync_p();
    rw = 1'b1;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      chk("no_load", 0, oe);
    end
    // Single clock mode read, then back-to-back writes to one pair
    sc_mode = 1'b1;
    rd(4'h2);
    sc_mode = 1'b0;
    wr(rows[1]);
    wr('{4'h2, 18'h2_4680, 18'h1_3579, 3'h5, 3'h6});
    rd(4'h2);
    // Mid-run reset clears drivers and echoes; reads work again afterwards
    @(negedge sys_clk);
    rst_n = 1'b0;
    @(negedge sys_clk);
    chk("echo_mid", 0, {en, ep});
    rst_n = 1'b1;
    repeat (2) begin
      @(posedge sys_clk);
      #1;
      chk("oe_mid", 0, oe);
    end
    rd(4'h0);
    print_verdict();
  end
endmodule
